//--- bench/its_far_end.sv
// far side model: trigger source and monitor of the strobed devices
`timescale 1ns/10ps

module its_far_end (
  // clock
  input wire logic clk,
  // trigger source control from the bench
  input wire logic holdHigh,
  input wire logic [31:0] syncCyc,
  output logic trigIn,
  // observed device outputs
  input wire logic singleStrobe,
  input wire logic contStrobe,
  input wire logic periodStart,
  input wire logic pixelReset,
  input wire logic pixValid,
  input wire logic [11:0] pixIndex,
  input wire its_pkg::its_zone_t pixZone
);
  import its_pkg::*;
  int cyc, psCount, psLast, psGap, prT, prWidth;
  int ssRises, ssT, ssWidth, ssDelay, csT, csHigh, onCnt, pvCount;
  logic [31:0] syncCnt = 32'h0;
  logic prD, ssD, csD;
  its_zone_t zoneOf [1:32];

  // ===================================================================
  // trigger source
  initial trigIn = 1'b0;

  // moved just after the rising edge, like every other bench input
  always @(posedge clk)
  begin
    syncCnt <= (syncCnt + 32'h1 >= syncCyc) ? 32'h0 : syncCnt + 32'h1;
    trigIn <= (syncCyc == 32'h0) ? holdHigh : (syncCnt < syncCyc / 2);
  end

  // ===================================================================
  // monitor, widths and delays in clock cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    prD <= pixelReset;
    ssD <= singleStrobe;
    csD <= contStrobe;
    if (periodStart)
    begin
      psCount <= psCount + 1;
      psGap <= cyc - psLast;
      psLast <= cyc;
    end
    if (pixelReset && !prD) prT <= cyc;
    if (!pixelReset && prD) prWidth <= cyc - prT;
    if (singleStrobe && !ssD)
    begin
      ssRises <= ssRises + 1;
      ssT <= cyc;
      ssDelay <= cyc - psLast;
    end
    if (!singleStrobe && ssD) ssWidth <= cyc - ssT;
    if (contStrobe && !csD) csT <= cyc;
    if (!contStrobe && csD) csHigh <= cyc - csT;
    if (singleStrobe || contStrobe) onCnt <= onCnt + 1;
    if (pixValid)
    begin
      pvCount <= pvCount + 1;
      if (pixIndex != 12'h0 && pixIndex <= 12'h020)
        zoneOf[pixIndex] <= pixZone;
    end
  end
endmodule // its_far_end

//--- bench/tb.sv
// self-checking bench of the trigger sequencer and strobe generator
`timescale 1ns/10ps
`include "its_cfg.svh"

module tb;
  import its_pkg::*;
  // a short 2 us step stands in for the 1 ms coarse step
  localparam int MSC = 500;
  localparam int LIMIT = 120000;
  localparam logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
    8'h14};
  localparam logic [31:0] dflt [6] = '{32'h0, 32'h3e8, 32'h0, 32'h1,
    32'h3e8, 32'h1};
  localparam logic [7:0] wa [13] = '{8'h10, 8'h10, 8'h10, 8'h04, 8'h04,
    8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h0c, 8'h0c, 8'h18};
  // one single strobe per period is wanted, so no strobe alignment
  localparam logic [31:0] wd [13] = '{32'h63, 32'h03938701, 32'h64,
    32'h9, 32'h03e7fc19, 32'h03e7fc18, 32'h14, 32'h7531, 32'h7530,
    32'h5, 32'h0, 32'h3, 32'hffffffff};
  localparam logic [31:0] we [13] = '{32'h3e8, 32'h3e8, 32'h64, 32'h3e8,
    32'h3e8, 32'h03e7fc18, 32'h14, 32'h0, 32'h7530, 32'h5, 32'h1, 32'h3,
    32'h0};
  localparam int zi [8] = '{1, 5, 6, 18, 19, 21, 22, 32};
  localparam logic [1:0] zz [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2,
    2'h3, 2'h3};
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic holdHigh = 1'b0;
  logic [31:0] syncCyc = 32'h0;
  logic hreadyout, hresp, trigIn, lampEnable, singleStrobe, contStrobe;
  logic periodStart, pixelReset, pixValid;
  logic [31:0] hrdata, rd;
  logic [11:0] pixIndex;
  its_zone_t pixZone;
  int nErrors = 0, nCompared = 0, cycles = 0, base;

  always #2 clk = ~clk;

  its_top #(.MS_CYC(MSC)) its_top_inst (.clk(clk), .rst_n(rstN),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .trigIn(trigIn), .lampEnable(lampEnable), .singleStrobe(singleStrobe),
    .contStrobe(contStrobe), .periodStart(periodStart),
    .pixelReset(pixelReset), .pixValid(pixValid), .pixIndex(pixIndex),
    .pixZone(pixZone));

  its_far_end its_far_end_inst (.clk(clk), .holdHigh(holdHigh),
    .syncCyc(syncCyc), .trigIn(trigIn), .singleStrobe(singleStrobe),
    .contStrobe(contStrobe), .periodStart(periodStart),
    .pixelReset(pixelReset), .pixValid(pixValid), .pixIndex(pixIndex),
    .pixZone(pixZone));

  // ===================================================================
  // reporting
  task automatic complete_run();
    $display("errors %0d compared %0d", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      nErrors++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int lo, input int hi);
    nCompared++;
    if (got < lo || got > hi)
    begin
      nErrors++;
      $display("ERROR %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // ===================================================================
  // bus and timing helpers
  // waits on hready only; the timeout cuts a slave that never answers
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic do_reset();
    rstN <= 1'b0;
    repeat (5) @(posedge clk);
    rstN <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_ps(input int n);
    repeat (n)
      do @(posedge clk); while (periodStart !== 1'b1);
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      nErrors++;
      $display("ERROR %0t run did not finish", $time);
      complete_run();
    end
  end

  // ===================================================================
  // main sequence
  initial
  begin
    do_reset();
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, ofs[i], 32'h0);
      check_val(rd, dflt[i]);
    end
    // gated capture, switched in before the first readout begins
    xfer(1'b1, `ITS_OFS_INT, 32'h14);
    xfer(1'b1, `ITS_OFS_CTRL, 32'h1);
    base = its_far_end_inst.pvCount;
    repeat (6000) @(posedge clk);
    check_cnt(its_far_end_inst.pvCount - base, 0, 0);
    holdHigh <= 1'b1;
    repeat (15000) @(posedge clk);
    check_cnt(its_far_end_inst.pvCount - base, 25, 60);
    for (int i = 0; i < 8; i++)
      check_val(32'(its_far_end_inst.zoneOf[zi[i]]), 32'(zz[i]));
    // ranges and modes after a second reset
    holdHigh <= 1'b0;
    do_reset();
    for (int i = 0; i < 13; i++)
    begin
      xfer(1'b1, wa[i], wd[i]);
      xfer(1'b0, wa[i], 32'h0);
      check_val(rd, we[i]);
    end
    for (int m = 3; m >= 0; m--)
    begin
      xfer(1'b1, `ITS_OFS_CTRL, 32'(m));
      xfer(1'b0, `ITS_OFS_CTRL, 32'h0);
      check_val(rd, 32'(m));
    end
    base = its_far_end_inst.onCnt;
    wait_ps(3);
    check_cnt(its_far_end_inst.onCnt - base, 0, 0);
    check_val(32'(lampEnable), 32'h0);
    check_cnt(its_far_end_inst.psGap, 5000, 5002);
    check_cnt(its_far_end_inst.prWidth, 3000, 3000);
    xfer(1'b1, `ITS_OFS_CTRL, 32'h4);
    wait_ps(1);
    check_val(32'(lampEnable), 32'h1);
    base = its_far_end_inst.ssRises;
    wait_ps(3);
    check_cnt(its_far_end_inst.ssRises - base, 3, 3);
    check_cnt(its_far_end_inst.ssWidth, 750, 750);
    check_cnt(its_far_end_inst.ssDelay, 1248, 1256);
    do @(posedge clk); while (contStrobe !== 1'b1);
    do @(posedge clk); while (contStrobe !== 1'b0);
    // let the monitor take in the falling edge first
    @(posedge clk);
    check_cnt(its_far_end_inst.csHigh, 12500, 12500);
    // single shot on a rising edge
    xfer(1'b1, `ITS_OFS_CTRL, 32'h6);
    repeat (10) @(posedge clk);
    base = its_far_end_inst.psCount;
    repeat (3000) @(posedge clk);
    check_cnt(its_far_end_inst.psCount - base, 0, 0);
    holdHigh <= 1'b1;
    repeat (1500) @(posedge clk);
    holdHigh <= 1'b0;
    repeat (500) @(posedge clk);
    holdHigh <= 1'b1;
    repeat (5000) @(posedge clk);
    check_cnt(its_far_end_inst.psCount - base, 1, 1);
    holdHigh <= 1'b0;
    repeat (50) @(posedge clk);
    holdHigh <= 1'b1;
    repeat (50) @(posedge clk);
    check_cnt(its_far_end_inst.psCount - base, 2, 2);
    // external clock, shorter than its 5 ms floor to keep the run short
    holdHigh <= 1'b0;
    xfer(1'b1, `ITS_OFS_CTRL, 32'h7);
    syncCyc <= 32'h00000fa0;
    wait_ps(3);
    check_cnt(its_far_end_inst.psGap, 4000, 4000);
    complete_run();
  end
endmodule // tb

//--- pkg/its_cfg.svh
// constants of the integration trigger and strobe timer
`ifndef ITS_CFG_SVH
`define ITS_CFG_SVH

// =====================================================================
// register byte offsets
`define ITS_OFS_CTRL 8'h00
`define ITS_OFS_INT 8'h04
`define ITS_OFS_SDLY 8'h08
`define ITS_OFS_SWID 8'h0c
`define ITS_OFS_CPER 8'h10
`define ITS_OFS_STAT 8'h14

// =====================================================================
// field positions
`define ITS_CTRL_MODE_LSB 0
`define ITS_CTRL_LAMP_BIT 2
`define ITS_STAT_OVR_BIT 3

// =====================================================================
// reset values
`define ITS_MODE_RST 2'h0
`define ITS_INT_RST 32'h000003e8
`define ITS_SDLY_RST 16'h0000
`define ITS_SWID_RST 16'h0001
`define ITS_CPER_RST 32'h000003e8

// =====================================================================
// accepted ranges, in microseconds
`define ITS_INT_MIN 32'h0000000a
`define ITS_INT_MAX 32'h03e7fc18
`define ITS_INT_FINE_LIM 32'h0009fe98
`define ITS_SDLY_MAX 32'h00007530
`define ITS_SWID_MIN 32'h00000001
`define ITS_SWID_MAX 32'h00007530
`define ITS_CPER_MIN 32'h00000064
`define ITS_CPER_MAX 32'h03938700
`define ITS_EXT_MIN_US 32'h00001388
`define ITS_EXT_MAX_US 32'h03938700

// =====================================================================
// timing
`define ITS_CLK_MHZ 250
`define ITS_US_CYC (1*`ITS_CLK_MHZ)
`define ITS_HALF_CYC (`ITS_CLK_MHZ/2)
`define ITS_XFER_US 12
`define ITS_XFER_CYC (`ITS_XFER_US*`ITS_CLK_MHZ)
`define ITS_STEP_FINE_US 10
`define ITS_STEP_FINE_CYC (`ITS_STEP_FINE_US*`ITS_CLK_MHZ)
`define ITS_STEP_COARSE_US 1000
`define ITS_STEP_COARSE_CYC (`ITS_STEP_COARSE_US*`ITS_CLK_MHZ)

// =====================================================================
// pixel readout order
`define ITS_PIX_BLACK_FIRST 12'h006
`define ITS_PIX_TRANS_FIRST 12'h013
`define ITS_PIX_ACTIVE_FIRST 12'h016
`define ITS_PIX_TAIL_FIRST 12'he56
`define ITS_PIX_LAST 12'he61

`endif

//--- pkg/its_pkg.sv
// types of the integration trigger and strobe timer
package its_pkg;

  // =====================================================================
  // trigger modes
  typedef enum logic [1:0] {
    MD_NORMAL = 2'h0,
    MD_SWGATE = 2'h1,
    MD_HWEDGE = 2'h2,
    MD_EXTSYNC = 2'h3
  } its_mode_t;

  // =====================================================================
  // period sequencer, gray along idle, transfer, integrate
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_XFER = 2'h1,
    ST_INTEG = 2'h3
  } its_state_t;

  // =====================================================================
  // pixel zones in readout order
  typedef enum logic [1:0] {
    ZN_UNUSE = 2'h0,
    ZN_BLACK = 2'h1,
    ZN_TRANS = 2'h2,
    ZN_ACTIVE = 2'h3
  } its_zone_t;

endpackage

//--- rtl/its_tick.sv
// restartable tick divider
`timescale 1ns/10ps
`include "its_cfg.svh"

module its_tick #(
  parameter int DIV = `ITS_US_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic clr,
  // one-cycle tick every DIV cycles
  output logic tick
);
  import its_pkg::*;

  localparam int W = $clog2(DIV + 1);

  logic [W-1:0] cnt_reg;
  wire atEnd = (cnt_reg == W'(DIV - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= atEnd & ~clr;
      cnt_reg <= (clr | atEnd) ? '0 : cnt_reg + 1'b1;
    end
  end
endmodule // its_tick

//--- rtl/its_top.sv
// integration trigger sequencer and strobe generator, ahb-lite slave
//
// Behaviour
// - four trigger modes chosen by software
// - normal mode runs periods back to back
// - gated mode captures after trigger input high
// - rising edge starts one programmed integration
// - external clock edges define each period
// - 12 us transfer and pixel reset
// - one delayed programmable strobe per period
// - strobe delay 0-30 ms, width 1us-30ms
// - strobes silent while lamp enable low
// - continuous strobe 50% duty, 100us-60s
// - readout order of 3681 pixel zones
// - continuous strobe divided from master clock
// - integration 10-65535000 us, else unchanged
// - 10 us steps, 1 ms above limit
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "its_cfg.svh"

module its_top #(
  parameter int MS_CYC = `ITS_STEP_COARSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // trigger pin
  input wire logic trigIn,
  // strobes and lamp
  output logic lampEnable,
  output logic singleStrobe,
  output logic contStrobe,
  // detector timing and readout
  output logic periodStart,
  output logic pixelReset,
  output logic pixValid,
  output logic [11:0] pixIndex,
  output its_pkg::its_zone_t pixZone
);
  import its_pkg::*;

  // =====================================================================
  // registers
  its_mode_t trigMode_reg;
  logic lampEn_reg;
  logic [31:0] intTime_reg;
  logic [15:0] sDly_reg, sWid_reg;
  logic [31:0] cPer_reg;
  logic [15:0] sDlyCur_reg, sWidCur_reg;
  logic [31:0] cPerCur_reg;
  logic [15:0] stepLim_reg, stepCnt_reg;
  logic stepFine_reg;
  its_state_t state_reg, stateNext;
  logic [11:0] xferCnt_reg;
  logic [15:0] sCnt_reg;
  logic [31:0] cCnt_reg;
  logic contRaw_reg;
  logic armed_reg, ovr_reg, rdBusy_reg;
  logic trigMeta_reg, trigSync_reg, trigLast_reg;
  logic wrPend_reg;
  logic [7:0] wAddr_reg;

  // =====================================================================
  // ahb-lite decode
  wire addrOk = hsel & htrans[1] & hready;
  wire rdAcc = addrOk & ~hwrite;
  wire wrAcc = addrOk & hwrite;
  wire wCtrl = wrPend_reg & (wAddr_reg == `ITS_OFS_CTRL);
  wire wInt = wrPend_reg & (wAddr_reg == `ITS_OFS_INT);
  wire wSdly = wrPend_reg & (wAddr_reg == `ITS_OFS_SDLY);
  wire wSwid = wrPend_reg & (wAddr_reg == `ITS_OFS_SWID);
  wire wCper = wrPend_reg & (wAddr_reg == `ITS_OFS_CPER);
  wire wStat = wrPend_reg & (wAddr_reg == `ITS_OFS_STAT);

  // out-of-range values are dropped, the old setting stays
  wire intOk = (hwdata >= `ITS_INT_MIN) & (hwdata <= `ITS_INT_MAX);
  wire sdlyOk = (hwdata <= `ITS_SDLY_MAX);
  wire swidOk = (hwdata >= `ITS_SWID_MIN) & (hwdata <= `ITS_SWID_MAX);
  wire cperOk = (hwdata >= `ITS_CPER_MIN) & (hwdata <= `ITS_CPER_MAX);
  wire [1:0] modeWr = hwdata[`ITS_CTRL_MODE_LSB +: 2];
  wire modeChg = wCtrl & (modeWr != trigMode_reg);

  wire [31:0] statWord = {24'h000000, singleStrobe, contStrobe,
    lampEn_reg, rdBusy_reg, ovr_reg, armed_reg, state_reg};
  wire [7:0] rAddr = haddr[7:0];
  wire [31:0] rdData =
    (rAddr == `ITS_OFS_CTRL) ? {29'h0, lampEn_reg, trigMode_reg} :
    (rAddr == `ITS_OFS_INT) ? intTime_reg :
    (rAddr == `ITS_OFS_SDLY) ? {16'h0000, sDly_reg} :
    (rAddr == `ITS_OFS_SWID) ? {16'h0000, sWid_reg} :
    (rAddr == `ITS_OFS_CPER) ? cPer_reg :
    (rAddr == `ITS_OFS_STAT) ? statWord : 32'h00000000;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wrPend_reg <= 1'b0;
      wAddr_reg <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_reg <= wrAcc;
      if (wrAcc)
        wAddr_reg <= rAddr;
      if (rdAcc)
        hrdata <= rdData;
    end
  end

  // =====================================================================
  // settings
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trigMode_reg <= its_mode_t'(`ITS_MODE_RST);
      lampEn_reg <= 1'b0;
      intTime_reg <= `ITS_INT_RST;
      sDly_reg <= `ITS_SDLY_RST;
      sWid_reg <= `ITS_SWID_RST;
      cPer_reg <= `ITS_CPER_RST;
    end
    else
    begin
      if (wCtrl)
      begin
        trigMode_reg <= its_mode_t'(modeWr);
        lampEn_reg <= hwdata[`ITS_CTRL_LAMP_BIT];
      end
      if (wInt && intOk)
        intTime_reg <= hwdata;
      if (wSdly && sdlyOk)
        sDly_reg <= hwdata[15:0];
      if (wSwid && swidOk)
        sWid_reg <= hwdata[15:0];
      if (wCper && cperOk)
        cPer_reg <= hwdata;
    end
  end

  // =====================================================================
  // trigger synchroniser
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trigMeta_reg <= 1'b0;
      trigSync_reg <= 1'b0;
      trigLast_reg <= 1'b0;
    end
    else
    begin
      trigMeta_reg <= trigIn;
      trigSync_reg <= trigMeta_reg;
      trigLast_reg <= trigSync_reg;
    end
  end

  wire trigRise = trigSync_reg & ~trigLast_reg;

  // =====================================================================
  // tick dividers
  logic usTick, halfTick, fineTick, msTick, startNow;

  its_tick #(.DIV(`ITS_US_CYC)) usDiv (.clk(clk), .rst_n(rst_n),
    .clr(startNow), .tick(usTick));
  its_tick #(.DIV(`ITS_HALF_CYC)) halfDiv (.clk(clk), .rst_n(rst_n),
    .clr(1'b0), .tick(halfTick));
  its_tick #(.DIV(`ITS_STEP_FINE_CYC)) fineDiv (.clk(clk), .rst_n(rst_n),
    .clr(startNow), .tick(fineTick));
  its_tick #(.DIV(MS_CYC)) msDiv (.clk(clk), .rst_n(rst_n),
    .clr(startNow), .tick(msTick));

  // =====================================================================
  // period sequencer
  wire freeRun = (trigMode_reg == MD_NORMAL) | (trigMode_reg == MD_SWGATE);
  wire hwMode = (trigMode_reg == MD_HWEDGE);
  wire extSync = (trigMode_reg == MD_EXTSYNC);
  wire stepTick = stepFine_reg ? fineTick : msTick;
  // the step count never ends a period inside the transfer, so tiny times stretch
  wire stepDone = (stepCnt_reg >= stepLim_reg);
  wire xferDone = (state_reg == ST_XFER) &
    (xferCnt_reg == 12'(`ITS_XFER_CYC - 1));
  wire edgeStart = trigRise &
    (extSync | (hwMode & (state_reg == ST_IDLE)));
  wire freeStart = freeRun & ((state_reg == ST_IDLE) |
    ((state_reg == ST_INTEG) & stepDone));
  assign startNow = ~modeChg & (edgeStart | freeStart);
  wire fineSel = (intTime_reg < `ITS_INT_FINE_LIM);
  wire [31:0] stepDiv = fineSel ? 32'(`ITS_STEP_FINE_US) :
    32'(`ITS_STEP_COARSE_US);
  wire [15:0] stepLimNext = 16'(intTime_reg / stepDiv);

  always_comb
  begin
    stateNext = state_reg;
    case (state_reg)
      ST_IDLE:
        if (startNow)
          stateNext = ST_XFER;
      ST_XFER:
        if (startNow)
          stateNext = ST_XFER;
        else if (xferDone)
          stateNext = ST_INTEG;
      ST_INTEG:
        if (startNow)
          stateNext = ST_XFER;
        else if (hwMode && stepDone)
          stateNext = ST_IDLE;
      default:
        stateNext = ST_IDLE;
    endcase
    if (modeChg)
      stateNext = ST_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      xferCnt_reg <= 12'h000;
      stepCnt_reg <= 16'h0000;
      periodStart <= 1'b0;
      pixelReset <= 1'b0;
    end
    else
    begin
      state_reg <= stateNext;
      periodStart <= startNow;
      pixelReset <= (stateNext == ST_XFER);
      xferCnt_reg <= startNow ? 12'h000 : xferCnt_reg + 12'h001;
      if (startNow)
        stepCnt_reg <= 16'h0000;
      else if (stepTick && !stepDone)
        stepCnt_reg <= stepCnt_reg + 16'h0001;
    end
  end

  // new settings are taken only as a period starts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sDlyCur_reg <= `ITS_SDLY_RST;
      sWidCur_reg <= `ITS_SWID_RST;
      cPerCur_reg <= `ITS_CPER_RST;
      stepLim_reg <= 16'h0001;
      stepFine_reg <= 1'b1;
    end
    else if (startNow)
    begin
      sDlyCur_reg <= sDly_reg;
      sWidCur_reg <= sWid_reg;
      cPerCur_reg <= cPer_reg;
      stepLim_reg <= stepLimNext;
      stepFine_reg <= fineSel;
    end
  end

  // =====================================================================
  // strobes
  wire periodOn = (state_reg != ST_IDLE);
  wire [16:0] sEnd = {1'b0, sDlyCur_reg} + {1'b0, sWidCur_reg};
  wire singleRaw = periodOn & (sCnt_reg >= sDlyCur_reg) &
    ({1'b0, sCnt_reg} < sEnd);
  wire cWrap = (cCnt_reg >= cPerCur_reg - 32'h00000001);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sCnt_reg <= 16'h0000;
      cCnt_reg <= 32'h00000000;
      contRaw_reg <= 1'b0;
      singleStrobe <= 1'b0;
      contStrobe <= 1'b0;
      lampEnable <= 1'b0;
    end
    else
    begin
      if (startNow)
        sCnt_reg <= 16'h0000;
      else if (usTick && sCnt_reg != 16'hffff)
        sCnt_reg <= sCnt_reg + 16'h0001;
      // half-us ticks, one period value per half, gives 50% duty
      if (halfTick)
      begin
        cCnt_reg <= cWrap ? 32'h00000000 : cCnt_reg + 32'h00000001;
        contRaw_reg <= contRaw_reg ^ cWrap;
      end
      lampEnable <= lampEn_reg;
      singleStrobe <= singleRaw & lampEn_reg;
      contStrobe <= contRaw_reg & lampEn_reg;
    end
  end

  // =====================================================================
  // capture gating and pixel readout
  wire gated = (trigMode_reg == MD_SWGATE);
  wire capWant = xferDone & (~gated | armed_reg);
  wire rdStart = capWant & ~rdBusy_reg;
  wire ovrSet = capWant & rdBusy_reg;
  wire armSet = gated & trigSync_reg;
  wire [11:0] pixNext = pixIndex + 12'h001;
  wire pixLast = (pixNext == `ITS_PIX_LAST);
  wire its_zone_t zoneNext =
    (pixNext < `ITS_PIX_BLACK_FIRST) ? ZN_UNUSE :
    (pixNext < `ITS_PIX_TRANS_FIRST) ? ZN_BLACK :
    (pixNext < `ITS_PIX_ACTIVE_FIRST) ? ZN_TRANS :
    (pixNext < `ITS_PIX_TAIL_FIRST) ? ZN_ACTIVE : ZN_UNUSE;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_reg <= 1'b0;
      ovr_reg <= 1'b0;
      rdBusy_reg <= 1'b0;
      pixValid <= 1'b0;
      pixIndex <= 12'h000;
      pixZone <= ZN_UNUSE;
    end
    else
    begin
      // set wins over consume and over software clear
      armed_reg <= armSet | (armed_reg & ~(rdStart & gated));
      ovr_reg <= ovrSet | (ovr_reg & ~(wStat & hwdata[`ITS_STAT_OVR_BIT]));
      pixValid <= 1'b0;
      if (rdStart)
      begin
        rdBusy_reg <= 1'b1;
        pixIndex <= 12'h000;
      end
      else if (rdBusy_reg && usTick)
      begin
        pixIndex <= pixNext;
        pixZone <= zoneNext;
        pixValid <= 1'b1;
        rdBusy_reg <= ~pixLast;
      end
    end
  end

  // =====================================================================
  // checks
  localparam int XFER_CYC_A = `ITS_XFER_CYC;
  logic [12:0] hlpXfer_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hlpXfer_reg <= 13'h0000;
    else if (periodStart)
      hlpXfer_reg <= 13'h0001;
    else if (pixelReset)
      hlpXfer_reg <= hlpXfer_reg + 13'h0001;
  end

  mode_default_a: assert property (@(posedge clk)
    $rose(rst_n) |-> trigMode_reg == MD_NORMAL)
    else $error("trigger mode not normal after reset");
  normal_loop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_INTEG && stepDone && trigMode_reg == MD_NORMAL
    && !modeChg) |=> state_reg == ST_XFER ##1 pixelReset)
    else $error("normal mode did not restart period");
  gate_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rdStart && gated) |-> armed_reg)
    else $error("gated capture without trigger");
  hw_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_IDLE && hwMode && trigRise && !modeChg)
    |=> periodStart ##1 state_reg == ST_XFER)
    else $error("hardware edge did not start period");
  hw_return_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_INTEG && hwMode && stepDone && !modeChg)
    |=> state_reg == ST_IDLE)
    else $error("hardware mode ran more than one period");
  ext_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
    (extSync && trigRise && !modeChg) |=> periodStart)
    else $error("external edge did not start period");
  xfer_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(pixelReset) && state_reg == ST_INTEG)
    |-> hlpXfer_reg == 13'(XFER_CYC_A))
    else $error("transfer length wrong");
  lamp_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !lampEn_reg |=> !singleStrobe && !contStrobe)
    else $error("strobe active without lamp enable");
  int_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wInt && !intOk) |=> $stable(intTime_reg))
    else $error("out of range integration time taken");
  trig_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    trigRise |=> !trigRise)
    else $error("one edge detected twice");
  cont_div_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(contRaw_reg) |-> $past(halfTick))
    else $error("continuous strobe moved off divider");
  strobe_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(sDlyCur_reg) || $changed(cPerCur_reg)
    |-> $past(startNow))
    else $error("strobe setting changed inside period");
  pix_zone_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pixValid && pixIndex == `ITS_PIX_ACTIVE_FIRST)
    |-> pixZone == ZN_ACTIVE)
    else $error("first active pixel zone wrong");
endmodule // its_top
